/* core/ddma_channel.v */
// Descriptor and autobuffer DMA channel with APB registers.
// Behaviour
// - Descriptor inactive until loaded into registers
// - Fetch rest only when ownership bit set
// - Ready bit write triggers descriptor load
// - At count zero write head back released
// - Data moves only after load and enable
// - Request bus, move when granted, update status
// - Chain on nonzero head, stop on zero
// - Five reads plus one write per descriptor
// - Memory-to-memory channel has no autobuffer
// - Autobuffer reloads setup, repeats until disabled
// - Autobuffer makes some config bits writable
// - Autobuffer interrupts at halfway and completion
// - Completion and port error interrupts exist
// - Two sticky status bits, write one clears
// - Config updated before next descriptor loads
// - Port errors sticky in bits 11-9
// - Ownership flag is config bit 15
// - Config bit 0 is channel enable
// - Status bit0 completion, bit1 error
// - Ready flag is bit 0 of ready register
//
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "ddma_defines.vh"
module ddma_channel
#(
    parameter MEMORY_TO_MEMORY_CHANNEL = 0
)
(
    input wire clk,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    output reg mem_req_q,
    output reg mem_we_q,
    output reg [15:0] mem_addr_q,
    output reg [15:0] mem_wdata_q,
    input wire mem_gnt,
    input wire [15:0] mem_rdata,
    output reg xfer_req_q,
    output reg [15:0] xfer_addr_q,
    output reg [7:0] xfer_page_q,
    output reg xfer_dir_q,
    input wire xfer_gnt,
    input wire [2:0] port_err,
    output reg irq_q
);
    localparam S_IDLE = 8'h01;
    localparam S_HEAD = 8'h02;
    localparam S_BODY = 8'h04;
    localparam S_WAIT = 8'h08;
    localparam S_XFER = 8'h10;
    localparam S_WBK = 8'h20;
    localparam S_NEXT = 8'h40;
    localparam S_RELD = 8'h80;

    reg [7:0] state_q;
    reg [15:0] cfg_q, srp_q, sra_q, cnt_q, cp_q, ptr_q, left_q, head_q;
    reg descriptor_ready_flag_q;
    reg complete_irq_pending_q, error_irq_pending_q;
    reg [2:0] idx_q;
    reg half_done_q;
    reg [15:0] cfg_d;
    reg acc_q;
    wire channel_enable = cfg_q[`DDMA_CFG_EN];
    wire autobuffer_select = cfg_q[`DDMA_CFG_AUTO] &&
        (MEMORY_TO_MEMORY_CHANNEL == 0);
    wire wr = psel && penable && pwrite && !pready;
    wire [15:0] wd = pwdata[15:0];
    wire [15:0] sra_reg_cnt;
    wire [15:0] half_cnt = {1'b0, sra_reg_cnt[15:1]};
    reg [15:0] head_addr_q;
    wire [15:0] orig_rd;
    reg [1:0] orig_ra;

    ddma_regs u_orig
    (
        .clk(clk),
        .we(wr && (paddr == `DDMA_OFF_SRP || paddr == `DDMA_OFF_SRA ||
            paddr == `DDMA_OFF_CNT)),
        .waddr(paddr[3:2] - 2'h2),
        .wdata(wd),
        .raddr(orig_ra),
        .rdata(orig_rd)
    );
    assign sra_reg_cnt = cnt_q;

    function mapped;
        input [11:0] a;
        begin
            mapped = (a <= `DDMA_OFF_ERR) && (a[1:0] == 2'b00);
        end
    endfunction

    always @*
    begin
        // In autobuffer mode extra config bits become writable.
        if (autobuffer_select)
            cfg_d = (cfg_q & ~`DDMA_CFG_SW_AUTO) | (wd & `DDMA_CFG_SW_AUTO);
        else
            cfg_d = (cfg_q & ~`DDMA_CFG_SW_DESC) | (wd & `DDMA_CFG_SW_DESC);
        if (MEMORY_TO_MEMORY_CHANNEL != 0)
            cfg_d[`DDMA_CFG_AUTO] = 1'b0;
    end

    // APB slave; every access takes one wait cycle.
    always @(posedge clk)
    begin
        if (rst)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
        else
        begin
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !mapped(paddr);
            if (psel && penable && !pready && !pwrite)
            begin
                case (paddr)
                    `DDMA_OFF_PTR: prdata <= {16'h0000, ptr_q};
                    `DDMA_OFF_CFG: prdata <= {16'h0000, cfg_q};
                    `DDMA_OFF_SRP: prdata <= {16'h0000, srp_q};
                    `DDMA_OFF_SRA: prdata <= {16'h0000, sra_q};
                    `DDMA_OFF_CNT: prdata <= {16'h0000, left_q};
                    `DDMA_OFF_CP: prdata <= {16'h0000, cp_q};
                    `DDMA_OFF_CPR: prdata <= {31'h0, descriptor_ready_flag_q};
                    `DDMA_OFF_IRQ: prdata <= {30'h0, error_irq_pending_q,
                        complete_irq_pending_q};
                    default: prdata <= 32'h00000000;
                endcase
            end
        end
    end

    always @(posedge clk)
    begin
        if (rst)
        begin
            state_q <= S_IDLE;
            cfg_q <= `DDMA_RST_16;
            srp_q <= `DDMA_RST_16;
            sra_q <= `DDMA_RST_16;
            cnt_q <= `DDMA_RST_16;
            cp_q <= `DDMA_RST_16;
            ptr_q <= `DDMA_RST_16;
            left_q <= `DDMA_RST_16;
            head_q <= `DDMA_RST_16;
            descriptor_ready_flag_q <= 1'b0;
            complete_irq_pending_q <= 1'b0;
            error_irq_pending_q <= 1'b0;
            idx_q <= 3'h0;
            half_done_q <= 1'b0;
            orig_ra <= 2'h0;
            acc_q <= 1'b0;
            mem_req_q <= 1'b0;
            mem_we_q <= 1'b0;
            mem_addr_q <= `DDMA_RST_16;
            mem_wdata_q <= `DDMA_RST_16;
            xfer_req_q <= 1'b0;
            xfer_addr_q <= `DDMA_RST_16;
            xfer_page_q <= 8'h00;
            xfer_dir_q <= 1'b0;
            irq_q <= 1'b0;
        end
        else
        begin
            irq_q <= complete_irq_pending_q || error_irq_pending_q;
            // Software writes; the hardware sets below win over clears.
            if (wr)
            begin
                case (paddr)
                    `DDMA_OFF_CFG: cfg_q <= cfg_d;
                    `DDMA_OFF_SRP: srp_q <= wd;
                    `DDMA_OFF_SRA: sra_q <= wd;
                    `DDMA_OFF_CNT: cnt_q <= wd;
                    `DDMA_OFF_CP: cp_q <= wd;
                    `DDMA_OFF_CPR: descriptor_ready_flag_q <= wd[0];
                    `DDMA_OFF_IRQ:
                    begin
                        if (wd[`DDMA_IRQ_COM])
                            complete_irq_pending_q <= 1'b0;
                        if (wd[`DDMA_IRQ_ERR])
                            error_irq_pending_q <= 1'b0;
                    end
                    default: ;
                endcase
            end
            // Port errors are sticky for the running transfer.
            if (state_q == S_XFER && port_err != 3'h0)
            begin
                cfg_q[`DDMA_CFG_ERR_HI:`DDMA_CFG_ERR_LO] <=
                    cfg_q[`DDMA_CFG_ERR_HI:`DDMA_CFG_ERR_LO] | port_err;
                if (cfg_q[`DDMA_CFG_ERRE])
                    error_irq_pending_q <= 1'b1;
            end
            case (state_q)
                S_IDLE:
                begin
                    if (descriptor_ready_flag_q && !autobuffer_select)
                    begin
                        descriptor_ready_flag_q <= 1'b0;
                        mem_req_q <= 1'b1;
                        mem_we_q <= 1'b0;
                        mem_addr_q <= cp_q;
                        state_q <= S_HEAD;
                    end
                    else if (channel_enable && autobuffer_select)
                    begin
                        left_q <= cnt_q;
                        ptr_q <= sra_q;
                        half_done_q <= 1'b0;
                        cfg_q[`DDMA_CFG_ERR_HI:`DDMA_CFG_ERR_LO] <= 3'h0;
                        state_q <= S_XFER;
                    end
                end
                S_HEAD:
                begin
                    if (mem_gnt)
                    begin
                        // Ownership clear: poll the head again.
                        if (mem_rdata[`DDMA_CFG_OWN])
                        begin
                            head_q <= mem_rdata;
                            mem_addr_q <= cp_q + 16'h0001;
                            idx_q <= 3'h1;
                            state_q <= S_BODY;
                        end
                    end
                end
                S_BODY:
                begin
                    if (mem_gnt)
                    begin
                        // Four more reads after the head.
                        case (idx_q)
                            3'h1: srp_q <= mem_rdata;
                            3'h2: sra_q <= mem_rdata;
                            3'h3: cnt_q <= mem_rdata;
                            default: cp_q <= mem_rdata;
                        endcase
                        mem_addr_q <= mem_addr_q + 16'h0001;
                        idx_q <= idx_q + 3'h1;
                        if (idx_q == `DDMA_DESC_WORDS - 3'h1)
                        begin
                            mem_req_q <= 1'b0;
                            ptr_q <= cp_q;
                            // Descriptor becomes active only now.
                            cfg_q <= {head_q[15:12], 3'h0, head_q[8:1],
                                cfg_q[`DDMA_CFG_EN] | head_q[0]};
                            state_q <= S_WAIT;
                        end
                    end
                end
                S_WAIT:
                begin
                    if (channel_enable)
                    begin
                        left_q <= cnt_q;
                        ptr_q <= sra_q;
                        half_done_q <= 1'b0;
                        state_q <= S_XFER;
                    end
                end
                S_XFER:
                begin
                    xfer_page_q <= srp_q[7:0];
                    xfer_dir_q <= cfg_q[`DDMA_CFG_DIR];
                    xfer_addr_q <= ptr_q;
                    xfer_req_q <= channel_enable && left_q != 16'h0000;
                    if (!channel_enable)
                    begin
                        xfer_req_q <= 1'b0;
                        state_q <= S_IDLE;
                    end
                    else if (left_q == 16'h0000)
                    begin
                        xfer_req_q <= 1'b0;
                        cfg_q[`DDMA_CFG_OWN] <= 1'b0;
                        cfg_q[`DDMA_CFG_DONE] <= 1'b1;
                        if (cfg_q[`DDMA_CFG_COME])
                            complete_irq_pending_q <= 1'b1;
                        if (autobuffer_select)
                        begin
                            orig_ra <= 2'h0;
                            state_q <= S_RELD;
                        end
                        else
                        begin
                            mem_req_q <= 1'b1;
                            mem_we_q <= 1'b1;
                            mem_addr_q <= head_addr_q;
                            mem_wdata_q <= {2'b01, cfg_q[13:0]};
                            state_q <= S_WBK;
                        end
                    end
                    else if (xfer_req_q && xfer_gnt)
                    begin
                        // One word per grant; count and pointer updated on each grant.
                        left_q <= left_q - 16'h0001;
                        ptr_q <= ptr_q + 16'h0001;
                        xfer_addr_q <= ptr_q + 16'h0001;
                        xfer_req_q <= left_q != 16'h0001;
                        if (autobuffer_select && !half_done_q &&
                            left_q - 16'h0001 == half_cnt)
                        begin
                            half_done_q <= 1'b1;
                            if (cfg_q[`DDMA_CFG_COME])
                                complete_irq_pending_q <= 1'b1;
                        end
                    end
                end
                S_WBK:
                begin
                    if (mem_gnt)
                    begin
                        mem_we_q <= 1'b0;
                        mem_addr_q <= cp_q;
                        state_q <= S_NEXT;
                    end
                end
                S_NEXT:
                begin
                    if (mem_gnt)
                    begin
                        if (mem_rdata == 16'h0000)
                        begin
                            mem_req_q <= 1'b0;
                            cfg_q[`DDMA_CFG_EN] <= 1'b0;
                            state_q <= S_IDLE;
                        end
                        else if (mem_rdata[`DDMA_CFG_OWN])
                        begin
                            head_q <= mem_rdata;
                            mem_addr_q <= cp_q + 16'h0001;
                            idx_q <= 3'h1;
                            cfg_q[`DDMA_CFG_ERR_HI:`DDMA_CFG_ERR_LO] <= 3'h0;
                            state_q <= S_BODY;
                        end
                    end
                end
                S_RELD:
                begin
                    // Copy the setup back one word a cycle; the memory
                    // answers one cycle after its address.
                    orig_ra <= orig_ra + 2'h1;
                    acc_q <= 1'b1;
                    if (acc_q)
                    begin
                        case (orig_ra)
                            2'h1: srp_q <= orig_rd;
                            2'h2: sra_q <= orig_rd;
                            default: cnt_q <= orig_rd;
                        endcase
                    end
                    if (acc_q && orig_ra == 2'h3)
                    begin
                        acc_q <= 1'b0;
                        cfg_q[`DDMA_CFG_ERR_HI:`DDMA_CFG_ERR_LO] <= 3'h0;
                        state_q <= S_IDLE;
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    always @(posedge clk)
    begin
        if (rst)
            head_addr_q <= `DDMA_RST_16;
        else if ((state_q == S_HEAD || state_q == S_NEXT) && mem_gnt)
            head_addr_q <= mem_addr_q;
    end
endmodule // ddma_channel

/* core/ddma_defines.vh */
// Register offsets, field positions and reset values of the descriptor DMA channel.
`ifndef DDMA_DEFINES_VH
`define DDMA_DEFINES_VH
`define DDMA_OFF_PTR 12'h000
`define DDMA_OFF_CFG 12'h004
`define DDMA_OFF_SRP 12'h008
`define DDMA_OFF_SRA 12'h00c
`define DDMA_OFF_CNT 12'h010
`define DDMA_OFF_CP 12'h014
`define DDMA_OFF_CPR 12'h018
`define DDMA_OFF_IRQ 12'h01c
`define DDMA_OFF_ERR 12'h020
`define DDMA_CFG_EN 0
`define DDMA_CFG_DIR 1
`define DDMA_CFG_COME 2
`define DDMA_CFG_AUTO 4
`define DDMA_CFG_ERRE 8
`define DDMA_CFG_ERR_LO 9
`define DDMA_CFG_ERR_HI 11
`define DDMA_CFG_DONE 14
`define DDMA_CFG_OWN 15
`define DDMA_CFG_SW_DESC 16'h0011
`define DDMA_CFG_SW_AUTO 16'h011f
`define DDMA_IRQ_COM 0
`define DDMA_IRQ_ERR 1
`define DDMA_RST_16 16'h0000
`define DDMA_DESC_WORDS 3'h5
`endif

/* core/ddma_regs.v */
// Small register memory holding the original autobuffer setup words.
`timescale 1ns/1ps
module ddma_regs
(
    input wire clk,
    input wire we,
    input wire [1:0] waddr,
    input wire [15:0] wdata,
    input wire [1:0] raddr,
    output reg [15:0] rdata
);
    reg [15:0] mem [0:3];

    always @(posedge clk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule // ddma_regs

/* testbench/ddma_channel_bench.sv */
// Register-level tests of the descriptor DMA channel.
`timescale 1ns/1ps
`include "ddma_defines.vh"
`define CHK(g, e) begin compares = compares + 1; if ((g) !== (e)) \
    begin err_count = err_count + 1; \
    $display("[FAIL] %0t got %h expected %h", $time, g, e); end end
module ddma_channel_bench;
    reg clk;
    reg rst;
    reg psel;
    reg penable;
    reg pwrite;
    reg [11:0] paddr;
    reg [31:0] pwdata;
    reg [2:0] port_err;
    wire [31:0] prdata;
    wire pready, pslverr, mem_req_q, mem_we_q, mem_gnt, xfer_req_q, xfer_gnt;
    wire irq_q, xfer_dir_q;
    wire [15:0] mem_addr_q, mem_wdata_q, mem_rdata, xfer_addr_q;
    wire [7:0] xfer_page_q;
    reg [31:0] rd;
    reg err;
    integer err_count = 0;
    integer compares = 0;
    integer n, x0, r0, w0;
    ddma_channel u_dut (.clk, .rst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .mem_req_q, .mem_we_q,
        .mem_addr_q, .mem_wdata_q, .mem_gnt, .mem_rdata, .xfer_req_q,
        .xfer_addr_q, .xfer_page_q, .xfer_dir_q, .xfer_gnt, .port_err, .irq_q);
    ddma_mem_model u_mem (.clk, .mem_req_q, .mem_we_q, .mem_addr_q,
        .mem_wdata_q, .mem_gnt, .mem_rdata, .xfer_req_q, .xfer_gnt);
    task apb(input [11:0] a, input w, input [31:0] d);
        integer k;
        begin
            psel <= 1'b1;
            paddr <= a;
            pwrite <= w;
            pwdata <= d;
            @(posedge clk);
            penable <= 1'b1;
            k = 0;
            @(posedge clk);
            while (pready !== 1'b1 && k < 20)
            begin
                @(posedge clk);
                k = k + 1;
            end
            if (pready !== 1'b1)
            begin
                err_count = err_count + 1;
                $display("[FAIL] %0t no bus answer", $time);
            end
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge clk);
        end
    endtask
    task wait_idle;
        integer k;
        begin
            k = 0;
            rd = 32'h1;
            while (rd[0] !== 1'b0 && k < 100)
            begin
                apb(`DDMA_OFF_CFG, 1'b0, 32'h0);
                k = k + 1;
            end
            `CHK(rd[0], 1'b0)
        end
    endtask
    task load(input [5:0] h, input [15:0] c, input [15:0] a,
        input [15:0] cnt, input [15:0] nx);
        begin
            u_mem.mem[h] = c;
            u_mem.mem[h + 1] = 16'h0000;
            u_mem.mem[h + 2] = a;
            u_mem.mem[h + 3] = cnt;
            u_mem.mem[h + 4] = nx;
        end
    endtask
    task print_verdict;
        begin
            $display("compares %0d mismatches %0d", compares, err_count);
            if (err_count == 0 && compares > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial
    begin
        #800000;
        err_count = err_count + 1;
        $display("[FAIL] %0t watchdog expired", $time);
        print_verdict;
    end
    initial
    begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        port_err = 3'h0;
        for (n = 0; n < 64; n = n + 1)
            u_mem.mem[n] = 16'h0000;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        apb(`DDMA_OFF_CFG, 1'b0, 32'h0);
        `CHK(rd, 32'h0)
        apb(`DDMA_OFF_IRQ, 1'b0, 32'h0);
        `CHK(rd, 32'h0)
        apb(12'h024, 1'b0, 32'h0);
        `CHK(err, 1'b1)
        apb(12'h006, 1'b1, 32'h1);
        `CHK(err, 1'b1)
        $display("test reset_values done");
        load(6'h10, 16'h8106, 16'h0100, 16'h0003, 16'h0020);
        r0 = u_mem.rd_cnt;
        w0 = u_mem.wr_cnt;
        x0 = u_mem.x_cnt;
        apb(`DDMA_OFF_CP, 1'b1, 32'h10);
        apb(`DDMA_OFF_CPR, 1'b1, 32'h1);
        repeat (20) @(posedge clk);
        `CHK(u_mem.x_cnt - x0, 0)
        apb(`DDMA_OFF_CFG, 1'b1, 32'h1);
        port_err <= 3'h5;
        repeat (6) @(posedge clk);
        port_err <= 3'h0;
        wait_idle;
        `CHK(rd[11:9], 3'h5)
        `CHK(u_mem.x_cnt - x0, 3)
        `CHK(u_mem.rd_cnt - r0, 6)
        `CHK(u_mem.wr_cnt - w0, 1)
        `CHK(u_mem.mem[16][15:14], 2'b01)
        `CHK(xfer_addr_q, 16'h0103)
        `CHK(xfer_dir_q, 1'b1)
        apb(`DDMA_OFF_IRQ, 1'b0, 32'h0);
        `CHK(rd[1:0], 2'h3)
        `CHK(irq_q, 1'b1)
        apb(`DDMA_OFF_IRQ, 1'b1, 32'h1);
        apb(`DDMA_OFF_IRQ, 1'b0, 32'h0);
        `CHK(rd[1:0], 2'h2)
        apb(`DDMA_OFF_IRQ, 1'b1, 32'h2);
        @(posedge clk);
        `CHK(irq_q, 1'b0)
        $display("test standalone done");
        load(6'h28, 16'h0004, 16'h0300, 16'h0002, 16'h0030);
        load(6'h30, 16'h8004, 16'h0400, 16'h0002, 16'h0020);
        x0 = u_mem.x_cnt;
        apb(`DDMA_OFF_CP, 1'b1, 32'h28);
        apb(`DDMA_OFF_CPR, 1'b1, 32'h1);
        repeat (20) @(posedge clk);
        `CHK(u_mem.last_rd, 16'h0028)
        u_mem.mem[40] <= 16'h8004;
        repeat (20) @(posedge clk);
        apb(`DDMA_OFF_CFG, 1'b1, 32'h1);
        wait_idle;
        `CHK(rd[14], 1'b1)
        `CHK(u_mem.x_cnt - x0, 4)
        `CHK(u_mem.mem[40][15:14], 2'b01)
        `CHK(u_mem.mem[48][15:14], 2'b01)
        `CHK(irq_q, 1'b1)
        apb(`DDMA_OFF_IRQ, 1'b1, 32'h3);
        $display("test chain done");
        apb(`DDMA_OFF_CFG, 1'b1, 32'h10);
        apb(`DDMA_OFF_SRP, 1'b1, 32'h2);
        apb(`DDMA_OFF_SRA, 1'b1, 32'h200);
        apb(`DDMA_OFF_CNT, 1'b1, 32'h4);
        r0 = u_mem.rd_cnt;
        x0 = u_mem.x_cnt;
        apb(`DDMA_OFF_CFG, 1'b1, 32'h15);
        n = 0;
        while (u_mem.x_cnt - x0 < 2 && n < 100)
        begin
            @(posedge clk);
            n = n + 1;
        end
        repeat (3) @(posedge clk);
        `CHK(irq_q, 1'b1)
        `CHK(u_mem.x_cnt - x0 < 4, 1'b1)
        while (u_mem.x_cnt - x0 < 10 && n < 400)
        begin
            @(posedge clk);
            n = n + 1;
        end
        `CHK(u_mem.x_cnt - x0 >= 10, 1'b1)
        `CHK(xfer_page_q, 8'h02)
        apb(`DDMA_OFF_CFG, 1'b0, 32'h0);
        `CHK(rd[4], 1'b1)
        apb(`DDMA_OFF_CFG, 1'b1, 32'h14);
        repeat (20) @(posedge clk);
        x0 = u_mem.x_cnt;
        repeat (20) @(posedge clk);
        `CHK(u_mem.x_cnt, x0)
        `CHK(u_mem.rd_cnt - r0, 0)
        $display("test autobuffer done");
        print_verdict;
    end
endmodule // ddma_channel_bench
bind ddma_channel ddma_channel_chk u_chk (.clk, .rst, .psel, .penable,
    .pwrite, .pready, .pslverr, .mem_req_q, .mem_we_q, .mem_addr_q,
    .mem_wdata_q, .mem_gnt, .xfer_req_q, .xfer_addr_q, .xfer_gnt, .irq_q);

/* testbench/ddma_channel_sva.sv */
// Concurrent checks on the ports of the descriptor DMA channel.
`timescale 1ns/1ps
module ddma_channel_chk
(
    input wire clk,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire pready,
    input wire pslverr,
    input wire mem_req_q,
    input wire mem_we_q,
    input wire [15:0] mem_addr_q,
    input wire [15:0] mem_wdata_q,
    input wire mem_gnt,
    input wire xfer_req_q,
    input wire [15:0] xfer_addr_q,
    input wire xfer_gnt,
    input wire irq_q
);
    wire apb_wr;
    // A pending bit can only drop through a write, so irq follows one.
    assign apb_wr = psel & penable & pwrite;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    chk_apb_answer: assert property
        (psel && penable && !pready |=> pready) else $error("no answer");
    chk_ready_pulse: assert property
        (pready |=> !pready) else $error("ready held");
    chk_err_ready: assert property
        (pslverr |-> pready) else $error("error without ready");
    chk_mem_hold: assert property
        (mem_req_q && !mem_gnt |=> mem_req_q && $stable(mem_addr_q)
        && $stable(mem_we_q)) else $error("memory request dropped");
    // A write that clears the enable may legally withdraw a request.
    chk_xfer_hold: assert property
        (xfer_req_q && !xfer_gnt && !apb_wr |=> xfer_req_q &&
        $stable(xfer_addr_q)) else $error("bus request dropped");
    chk_wb_status: assert property
        (mem_req_q && mem_we_q |-> mem_wdata_q[15:14] == 2'b01)
        else $error("bad head write back");
    chk_load_first: assert property
        (!(mem_req_q && xfer_req_q)) else $error("move during load");
    chk_irq_clear: assert property
        ($fell(irq_q) |-> $past(apb_wr, 1) || $past(apb_wr, 2))
        else $error("irq dropped without write");
    chk_rst_quiet: assert property
        (disable iff (1'b0) rst |=> !irq_q && !mem_req_q && !xfer_req_q)
        else $error("active in reset");
    cover property (mem_req_q && mem_we_q && mem_gnt);
    cover property ($rose(irq_q));
    cover property (pslverr);
endmodule // ddma_channel_chk

/* testbench/ddma_mem_model.sv */
// Behavioural data memory and DMA bus partner of the channel.
`timescale 1ns/1ps
module ddma_mem_model
(
    input wire clk,
    input wire mem_req_q,
    input wire mem_we_q,
    input wire [15:0] mem_addr_q,
    input wire [15:0] mem_wdata_q,
    output wire mem_gnt,
    output wire [15:0] mem_rdata,
    input wire xfer_req_q,
    output wire xfer_gnt
);
    reg [15:0] mem [0:63];
    reg [1:0] ph = 2'h0;
    reg [15:0] last_rd = 16'h0000;
    integer rd_cnt = 0;
    integer wr_cnt = 0;
    integer x_cnt = 0;
    // Grants come only every other cycle, so requests must be held.
    assign mem_gnt = mem_req_q & ph[0];
    // Outside a grant the lines toggle, so a stale word is never seen.
    assign mem_rdata = mem_gnt ? mem[mem_addr_q[5:0]] : {8{ph[0], ~ph[0]}};
    assign xfer_gnt = xfer_req_q & (ph == 2'h3);
    always @(posedge clk)
    begin
        ph <= ph + 2'h1;
        if (mem_gnt && mem_we_q)
        begin
            mem[mem_addr_q[5:0]] <= mem_wdata_q;
            wr_cnt <= wr_cnt + 1;
        end
        if (mem_gnt && !mem_we_q)
        begin
            rd_cnt <= rd_cnt + 1;
            last_rd <= mem_addr_q;
        end
        if (xfer_gnt)
            x_cnt <= x_cnt + 1;
    end
endmodule // ddma_mem_model
